// ---- common/pcg_pkg.sv ----
package pcg_pkg;
  // --------------------------------------------------------------------------
  // Divider widths and lock detector figures
  // --------------------------------------------------------------------------
  localparam int unsigned R_W = 4;
  localparam int unsigned N_W = 12;
  localparam int unsigned P_W = 2;
  localparam int unsigned L_W = 8;
  localparam int unsigned E_W = 2;
  localparam int unsigned CNT_W = 24;
  // Lock window on feedback periods counted per reference period
  localparam logic [CNT_W-1:0] LOCK_TOL = 24'h00_0002;
  localparam logic [CNT_W-1:0] ACQ_TOL = 24'h00_0010;
  // Nominal center-of-range step in Hz
  localparam int unsigned F_NOM_HZ = 38400;
  localparam int unsigned F_RDV_MIN_HZ = 30000;
  localparam int unsigned F_RDV_MAX_HZ = 100000;

  // Divider settings from software
  typedef struct packed {
    logic [R_W-1:0] ref_div;
    logic [N_W-1:0] fb_mod;
    logic [P_W-1:0] prescale;
    logic [L_W-1:0] lin_mult;
    logic [E_W-1:0] range_exp;
  } pcg_div_s;

  typedef enum logic [0:0] {PCG_ACQUIRE, PCG_TRACK} pcg_mode_e;
endpackage : pcg_pkg

// ---- rtl/pcg_clock_gen.sv ----
`timescale 1ns/100ps
module pcg_clock_gen (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_CRYSTAL_CLOCK,
  input wire logic I_VCO_CLOCK,
  input wire logic I_INTEGRATION_OSC_ENABLE,
  input wire logic I_OSC_RUN_IN_STOP,
  input wire logic I_MONITOR_MODE,
  input wire logic I_MONITOR_CLOCK_SELECT_PIN,
  input wire logic I_SELECT_VCO,
  input wire logic I_AUTO_BANDWIDTH,
  input wire logic I_FILTER_MODE_WR,
  input wire logic I_FILTER_MODE_BIT,
  input wire logic I_LOCK_CHANGE_IRQ_ENABLE,
  input wire pcg_pkg::pcg_div_s I_DIV,
  output logic O_OSC_ENABLE,
  output logic O_PLL_REFERENCE_CLOCK,
  output logic O_DIVIDED_REFERENCE_CLOCK,
  output logic O_VCO_FEEDBACK_CLOCK,
  output logic O_PUMP_UP,
  output logic O_PUMP_DOWN,
  output logic O_FILTER_MODE_BIT,
  output logic O_LOCK,
  output logic O_LOCK_IRQ,
  output logic O_BASE_CLOCK_OUT,
  output logic O_BUS_CLOCK,
  output logic O_VCO_SELECTED,
  output logic [31:0] O_CENTER_FREQ_HZ
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam int unsigned NS = 7;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  // Delayed copy of the two synced clock pins, for edge detection only
  logic [1:0] prev_q;
  assign raw_in = {I_CRYSTAL_CLOCK, I_VCO_CLOCK, I_INTEGRATION_OSC_ENABLE, I_OSC_RUN_IN_STOP,
                   I_MONITOR_MODE, I_MONITOR_CLOCK_SELECT_PIN, I_SELECT_VCO};
  // Two stages; all pins arrive from outside this clock
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (I_CE) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q[6:5];
    end
  end

  logic xtal_s, vco_s, mon_s, mon_sel_s, sel_vco_s;
  logic xtal_rise, vco_rise;
  assign xtal_s = sync2_q[6];
  assign vco_s = sync2_q[5];
  assign mon_s = sync2_q[2];
  assign mon_sel_s = sync2_q[1];
  assign sel_vco_s = sync2_q[0];
  // Sampled clocks must stay below half the sample rate, else edges are lost
  assign xtal_rise = xtal_s & ~prev_q[1];
  assign vco_rise = vco_s & ~prev_q[0];

  // Oscillator enable from either source
  assign O_OSC_ENABLE = sync2_q[4] | sync2_q[3];
  assign O_PLL_REFERENCE_CLOCK = xtal_s;

  // --------------------------------------------------------------------------
  // Reference divider and feedback divider chain
  // --------------------------------------------------------------------------
  logic [pcg_pkg::R_W-1:0] rcnt_q;
  logic rdv_q, rdv_tick;
  logic [7:0] pcnt_q;
  logic [pcg_pkg::N_W-1:0] ncnt_q;
  logic vdv_q, vdv_tick, pre_tick;
  logic [7:0] pre_last;
  assign pre_last = 8'((9'h001 << I_DIV.prescale) - 9'h001);
  // Ratios of zero or one divide by one; a zero ratio would otherwise wrap
  logic r_by_one, n_by_one;
  assign r_by_one = (I_DIV.ref_div[pcg_pkg::R_W-1:1] == '0);
  assign n_by_one = (I_DIV.fb_mod[pcg_pkg::N_W-1:1] == '0);
  assign rdv_tick = xtal_rise & (r_by_one | (rcnt_q >= I_DIV.ref_div - 1'b1));
  assign pre_tick = vco_rise & (pcnt_q >= pre_last);
  assign vdv_tick = pre_tick & (n_by_one | (ncnt_q >= I_DIV.fb_mod - 1'b1));
  // Modulo counters; zero ratios behave as divide by one
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rcnt_q <= '0;
      pcnt_q <= '0;
      ncnt_q <= '0;
      rdv_q <= 1'b0;
      vdv_q <= 1'b0;
    end else if (I_CE) begin
      if (xtal_rise) rcnt_q <= rdv_tick ? '0 : rcnt_q + 1'b1;
      if (vco_rise) pcnt_q <= pre_tick ? '0 : pcnt_q + 8'h01;
      if (pre_tick) ncnt_q <= vdv_tick ? '0 : ncnt_q + 1'b1;
      if (rdv_tick) rdv_q <= ~rdv_q;
      if (vdv_tick) vdv_q <= ~vdv_q;
    end
  end
  assign O_DIVIDED_REFERENCE_CLOCK = rdv_q;
  assign O_VCO_FEEDBACK_CLOCK = vdv_q;

  // --------------------------------------------------------------------------
  // Phase detector: tri-state up/down pump
  // --------------------------------------------------------------------------
  logic up_q, dn_q;
  // Width of pulse equals edge-to-edge lag, sign gives direction
  // Resolution is one sample period; finer phase error is invisible here
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (I_CE) begin
      up_q <= (up_q | rdv_tick) & ~(vdv_tick | dn_q & rdv_tick) & ~(up_q & vdv_tick);
      dn_q <= (dn_q | vdv_tick) & ~(rdv_tick | up_q & vdv_tick) & ~(dn_q & rdv_tick);
    end
  end
  assign O_PUMP_UP = up_q;
  assign O_PUMP_DOWN = dn_q;

  // --------------------------------------------------------------------------
  // Lock detector: feedback edges counted per reference period
  // --------------------------------------------------------------------------
  logic [pcg_pkg::CNT_W-1:0] fcnt_q, diff;
  logic lock_q, lock_prev_q, irq_q, in_lock, in_track;
  pcg_pkg::pcg_mode_e mode_q;
  // Target is one feedback period per reference period
  // Coarse on purpose: counting whole edges keeps the detector small
  assign diff = (fcnt_q > 24'h00_0001) ? fcnt_q - 24'h00_0001 : 24'h00_0001 - fcnt_q;
  assign in_lock = diff < pcg_pkg::LOCK_TOL;
  assign in_track = diff < pcg_pkg::ACQ_TOL;
  // One evaluation per divided reference period, on its falling toggle
  logic rdv_eval, vdv_fall;
  assign rdv_eval = rdv_tick & rdv_q;
  assign vdv_fall = vdv_tick & vdv_q;
  // Evaluated once per reference period, so speed follows reference rate
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      fcnt_q <= '0;
      lock_q <= 1'b0;
      lock_prev_q <= 1'b0;
      irq_q <= 1'b0;
      mode_q <= pcg_pkg::PCG_ACQUIRE;
    end else if (I_CE) begin
      if (rdv_eval) fcnt_q <= {{(pcg_pkg::CNT_W-1){1'b0}}, vdv_fall};
      else if (vdv_fall) fcnt_q <= fcnt_q + 24'h00_0001;
      if (!I_AUTO_BANDWIDTH) begin
        lock_q <= 1'b0;
        if (I_FILTER_MODE_WR)
          mode_q <= I_FILTER_MODE_BIT ? pcg_pkg::PCG_TRACK : pcg_pkg::PCG_ACQUIRE;
      end else if (rdv_eval) begin
        lock_q <= in_lock;
        mode_q <= in_track ? pcg_pkg::PCG_TRACK : pcg_pkg::PCG_ACQUIRE;
      end
      lock_prev_q <= lock_q;
      irq_q <= I_AUTO_BANDWIDTH & I_LOCK_CHANGE_IRQ_ENABLE & (lock_q ^ lock_prev_q);
    end
  end
  assign O_LOCK = lock_q;
  assign O_LOCK_IRQ = irq_q;
  assign O_FILTER_MODE_BIT = (mode_q == pcg_pkg::PCG_TRACK);

  // Center-of-range figure for software checks
  logic [31:0] cfreq_d, cfreq_q;
  assign cfreq_d = 32'(32'(I_DIV.lin_mult) * (32'h0000_0001 << I_DIV.range_exp) * pcg_pkg::F_NOM_HZ);
  // Registered so the port is a flop; one cycle behind quasi-static settings
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfreq_q <= '0;
    end else if (I_CE) begin
      cfreq_q <= cfreq_d;
    end
  end
  assign O_CENTER_FREQ_HZ = cfreq_q;

  // --------------------------------------------------------------------------
  // Base clock selector
  // --------------------------------------------------------------------------
  logic xhalf_q, vhalf_q, use_vco_q, base_q, bus_q, want_vco;
  // Monitor mode lets the select pin pick the source
  assign want_vco = mon_s ? mon_sel_s : sel_vco_s;
  // Switch only while both halves low and base low: no runt pulses
  // Trade-off: a switch waits until both halves are low at once, which has no fixed bound
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      xhalf_q <= 1'b0;
      vhalf_q <= 1'b0;
      use_vco_q <= 1'b0;
      base_q <= 1'b0;
      bus_q <= 1'b0;
    end else if (I_CE) begin
      if (xtal_rise) xhalf_q <= ~xhalf_q;
      if (vco_rise) vhalf_q <= ~vhalf_q;
      if (want_vco != use_vco_q && !base_q && !xhalf_q && !vhalf_q) use_vco_q <= want_vco;
      if ((use_vco_q ? vco_rise : xtal_rise)) begin
        base_q <= use_vco_q ? ~vhalf_q : ~xhalf_q;
        if (!base_q) bus_q <= ~bus_q;
      end
    end
  end
  assign O_BASE_CLOCK_OUT = base_q;
  assign O_BUS_CLOCK = bus_q;
  assign O_VCO_SELECTED = use_vco_q;
endmodule : pcg_clock_gen

// ---- tb/pcg_clock_source.sv ----
`timescale 1ns/100ps
module pcg_clock_source #(parameter int XHALF = 6) (
  input wire logic i_clk,
  input wire logic i_osc_en,
  input wire logic [7:0] i_vco_half,
  output logic o_xtal = 1'h0,
  output logic o_vco = 1'h0
);
  int xc = 0;
  int vc = 0;
  // --------------------------------
  // Crystal and VCO sources
  // --------------------------------
  // Crystal stands still while the oscillator is off; VCO runs free
  always @(posedge i_clk) begin
    xc = i_osc_en ? xc + 1 : 0;
    vc = vc + 1;
    if (xc >= XHALF) begin
      xc = 0;
      o_xtal <= ~o_xtal;
    end
    if (vc >= int'(i_vco_half)) begin
      vc = 0;
      o_vco <= ~o_vco;
    end
  end
endmodule : pcg_clock_source

// ---- tb/pcg_clock_gen_asserts.sv ----
`timescale 1ns/100ps
module pcg_clock_gen_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_INTEGRATION_OSC_ENABLE,
  input wire logic I_OSC_RUN_IN_STOP,
  input wire logic I_AUTO_BANDWIDTH,
  input wire pcg_pkg::pcg_div_s I_DIV,
  input wire logic O_OSC_ENABLE,
  input wire logic O_BASE_CLOCK_OUT,
  input wire logic O_BUS_CLOCK,
  input wire logic O_LOCK,
  input wire logic O_LOCK_IRQ,
  input wire logic O_PUMP_UP,
  input wire logic O_PUMP_DOWN,
  input wire logic [31:0] O_CENTER_FREQ_HZ
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // --------------------------------
  // Port relations
  // --------------------------------
  a_osc_on: assert property ((I_CE && (I_INTEGRATION_OSC_ENABLE || I_OSC_RUN_IN_STOP))[*4] |-> O_OSC_ENABLE)
    else $error("oscillator enable missing");
  a_osc_off: assert property ((I_CE && !I_INTEGRATION_OSC_ENABLE && !I_OSC_RUN_IN_STOP)[*4] |-> !O_OSC_ENABLE)
    else $error("oscillator enabled without cause");
  a_bus_follow: assert property ($changed(O_BUS_CLOCK) |->
    $changed(O_BASE_CLOCK_OUT) || $past(O_BASE_CLOCK_OUT) != $past(O_BASE_CLOCK_OUT, 2))
    else $error("bus clock moved without base clock");
  a_manual_nolock: assert property ((!I_AUTO_BANDWIDTH)[*6] |-> !O_LOCK && !O_LOCK_IRQ)
    else $error("lock active in manual mode");
  a_irq_single: assert property (O_LOCK_IRQ |=> !O_LOCK_IRQ)
    else $error("lock irq longer than one cycle");
  a_irq_cause: assert property (O_LOCK_IRQ |-> $past(O_LOCK) != $past(O_LOCK, 2))
    else $error("lock irq without lock change");
  a_center_freq: assert property ($stable(I_DIV)[*2] |-> O_CENTER_FREQ_HZ ==
    32'(I_DIV.lin_mult) * (32'h0000_0001 << I_DIV.range_exp) * pcg_pkg::F_NOM_HZ)
    else $error("center frequency wrong");
  a_base_runt: assert property ($rose(O_BASE_CLOCK_OUT) |=> O_BASE_CLOCK_OUT[*3])
    else $error("runt pulse on base clock");
  a_pump_excl: assert property (!(O_PUMP_UP && O_PUMP_DOWN))
    else $error("both pump outputs active");
  a_ce_freeze: assert property (!I_CE |=> $stable(O_BASE_CLOCK_OUT) && $stable(O_BUS_CLOCK) && $stable(O_LOCK))
    else $error("state moved while clock enable low");
endmodule : pcg_clock_gen_asserts
bind pcg_clock_gen pcg_clock_gen_asserts u_chk (.*);

// ---- tb/tb_pcg_clock_gen.sv ----
`timescale 1ns/100ps
module tb_pcg_clock_gen;
  logic clk = 1'h0, rst = 1'h1, osc_int = 1'h0, osc_stop = 1'h0, sel_vco = 1'h0, auto_bw = 1'h0;
  logic fm_wr = 1'h0, fm_bit = 1'h0, irq_en = 1'h1, ce = 1'h1, mon = 1'h0, mon_sel = 1'h0;
  logic [7:0] vhalf = 8'h03;
  pcg_pkg::pcg_div_s dv = '0;
  logic xtal, vco, osc_en, pref, ref_dv, fb, base, bus, fmode, lock, irq, vsel, pu, pd;
  logic [31:0] cfreq, got;
  logic [31:0] exp_x [5] = '{32'h0000_0006, 32'h0000_0024, 32'h0000_0024, 32'h0000_000C, 32'h0000_0018};
  int n_mismatch = 0, comparisons = 0, irq_n = 0, pu_n = 0, pd_n = 0, mark_u = 0, mark_d = 0;
  wire [4:0] tap = {bus, base, fb, ref_dv, pref};
  // --------------------------------
  // Clock, partner and design
  // --------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) if (irq === 1'h1) irq_n++;
  // Cycles spent with each pump output high
  always @(posedge clk) if (pu === 1'h1) pu_n++;
  always @(posedge clk) if (pd === 1'h1) pd_n++;
  pcg_clock_source src (.i_clk(clk), .i_osc_en(osc_en), .i_vco_half(vhalf), .o_xtal(xtal), .o_vco(vco));
  pcg_clock_gen dut (.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CRYSTAL_CLOCK(xtal), .I_VCO_CLOCK(vco),
    .I_INTEGRATION_OSC_ENABLE(osc_int), .I_OSC_RUN_IN_STOP(osc_stop), .I_MONITOR_MODE(mon),
    .I_MONITOR_CLOCK_SELECT_PIN(mon_sel), .I_SELECT_VCO(sel_vco), .I_AUTO_BANDWIDTH(auto_bw),
    .I_FILTER_MODE_WR(fm_wr), .I_FILTER_MODE_BIT(fm_bit), .I_LOCK_CHANGE_IRQ_ENABLE(irq_en), .I_DIV(dv),
    .O_OSC_ENABLE(osc_en), .O_PLL_REFERENCE_CLOCK(pref), .O_DIVIDED_REFERENCE_CLOCK(ref_dv),
    .O_VCO_FEEDBACK_CLOCK(fb), .O_PUMP_UP(pu), .O_PUMP_DOWN(pd), .O_FILTER_MODE_BIT(fmode), .O_LOCK(lock),
    .O_LOCK_IRQ(irq), .O_BASE_CLOCK_OUT(base), .O_BUS_CLOCK(bus), .O_VCO_SELECTED(vsel),
    .O_CENTER_FREQ_HZ(cfreq));
  // --------------------------------
  // Access tasks
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Cycles between two toggles of one tap, after syncing to a toggle
  task automatic gap(input int k, output logic [31:0] n);
    logic v;
    repeat (2) begin
      v = tap[k];
      n = 0;
      while (tap[k] === v && n < 2000) begin
        @(posedge clk);
        n++;
      end
    end
  endtask : gap
  task automatic wr_mode(input logic b);
    @(posedge clk);
    fm_bit <= b;
    fm_wr <= 1'h1;
    @(posedge clk);
    fm_wr <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : wr_mode
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 3000 && lock !== v; i++) @(posedge clk);
  endtask : wait_lock
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Watchdog sized well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      {osc_int, osc_stop} <= 2'(k);
      repeat (6) @(posedge clk);
      check(32'(osc_en), 32'(k != 0));
    end
    $display("oscillator test done");
    dv <= '{ref_div: 4'h3, fb_mod: 12'h003, prescale: 2'h1, lin_mult: 8'hD1, range_exp: 2'h2};
    repeat (100) @(posedge clk);
    check(cfreq, 32'h01E9_D800);
    foreach (exp_x[k]) begin
      gap(k, got);
      check(got, exp_x[k]);
    end
    sel_vco <= 1'h1;
    repeat (60) @(posedge clk);
    check(32'(vsel), 32'h0000_0001);
    gap(3, got);
    check(got, 32'h0000_0006);
    gap(4, got);
    check(got, 32'h0000_000C);
    mon <= 1'h1;
    repeat (60) @(posedge clk);
    check(32'(vsel), 32'h0000_0000);
    gap(3, got);
    check(got, 32'h0000_000C);
    mon_sel <= 1'h1;
    repeat (60) @(posedge clk);
    check(32'(vsel), 32'h0000_0001);
    mon <= 1'h0;
    $display("divider test done");
    wr_mode(1'h1);
    check({fmode, lock}, 32'h0000_0002);
    wr_mode(1'h0);
    check({fmode, lock, 30'(irq_n)}, 32'h0000_0000);
    $display("manual test done");
    dv <= '{ref_div: 4'h1, fb_mod: 12'h002, prescale: 2'h0, lin_mult: 8'h80, range_exp: 2'h0};
    auto_bw <= 1'h1;
    wait_lock(1'h1);
    repeat (40) @(posedge clk);
    check({fmode, lock, 30'(irq_n)}, 32'hC000_0001);
    wr_mode(1'h0);
    check(32'(fmode), 32'h0000_0001);
    dv.ref_div <= 4'h8;
    wait_lock(1'h0);
    repeat (4) @(posedge clk);
    check({lock, 31'(irq_n)}, 32'h0000_0002);
    mark_u = pu_n;
    mark_d = pd_n;
    repeat (192) @(posedge clk);
    check(32'(pu_n == mark_u), 32'h0000_0001);
    check(32'(pd_n - mark_d > 120), 32'h0000_0001);
    $display("lock test done");
    ce <= 1'h0;
    @(posedge clk);
    got = 32'({lock, fmode, tap});
    repeat (20) @(posedge clk);
    check(32'({lock, fmode, tap}), got);
    ce <= 1'h1;
    $display("enable test done");
    close_out();
  end
endmodule : tb_pcg_clock_gen
